/* inc/level_monitor_pkg.sv */
// Constants shared by the level-detect and signal-monitor block
package level_monitor_pkg;
    // ==========================================================
    // Widths and counts
    localparam int NCH     = 2;   // Converter channels
    localparam int MAG_W   = 13;  // Output magnitude width
    localparam int LVL_W   = 4;   // Early-stage fast level code
    localparam int PER_W   = 24;  // Measurement period width
    localparam int DWELL_W = 16;  // Dwell time width
    localparam int RES_W   = 20;  // Monitor result width
    localparam int ACC_W   = 24;  // Power accumulator width
    localparam int PWR_W   = 11;  // Per-sample power width
    localparam int ROOT_W  = 12;  // Square root width
    localparam int NKIND   = 3;   // Rms, peak, crossing
    localparam int SER_W   = NCH * NKIND * RES_W;
    localparam int LEFT_W  = 7;   // Serial bit counter width
    // ==========================================================
    // Latencies in sample clocks and scaling shifts
    localparam int OVR_LAT = 12;  // Pipeline overrange delay
    localparam int FD_SLOW = 4;   // Extra pin stages, modes 1..3
    localparam int PWR_SHIFT = 15; // Power scaling
    localparam int RES_SHIFT = 8;  // Root to result alignment
    // ==========================================================
    // Register offsets
    localparam logic [9:0] ADR_FD_SEL  = 10'h104;
    localparam logic [9:0] ADR_COARSE  = 10'h105;
    localparam logic [9:0] ADR_FHI_L   = 10'h106;
    localparam logic [9:0] ADR_FHI_H   = 10'h107;
    localparam logic [9:0] ADR_FLO_L   = 10'h108;
    localparam logic [9:0] ADR_FLO_H   = 10'h109;
    localparam logic [9:0] ADR_DWL_L   = 10'h10A;
    localparam logic [9:0] ADR_DWL_H   = 10'h10B;
    localparam logic [9:0] ADR_SER     = 10'h111;
    localparam logic [9:0] ADR_MON     = 10'h112;
    localparam logic [9:0] ADR_PER0    = 10'h113;
    localparam logic [9:0] ADR_PER1    = 10'h114;
    localparam logic [9:0] ADR_PER2    = 10'h115;
    localparam logic [9:0] ADR_RES     = 10'h116;
    localparam logic [9:0] ADR_RES_END = 10'h11B;
    // ==========================================================
    // Field positions and reset value
    localparam int FD_SEL_LSB   = 1;
    localparam int MON_EN_BIT   = 0;
    localparam int MON_MODE_LSB = 1;
    localparam int SER_RMS_BIT  = 0;
    localparam int SER_PEAK_BIT = 1;
    localparam int SER_XING_BIT = 2;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // ==========================================================
    // Fast detect pin modes
    localparam logic [2:0] FD_MAG       = 3'h0;
    localparam logic [2:0] FD_MAG_OVR   = 3'h1;
    localparam logic [2:0] FD_MAG_OVR_L = 3'h2;
    localparam logic [2:0] FD_MAG_CU_L  = 3'h3;
    localparam logic [2:0] FD_TRIPS     = 3'h4;
    localparam logic [2:0] FD_GAIN      = 3'h5;
    // Monitor modes
    localparam logic [1:0] MON_RMS  = 2'h0;
    localparam logic [1:0] MON_PEAK = 2'h1;
endpackage

/* rtl/level_monitor.sv */
// Level detection, gain flags and signal monitor for both channels
//
// Operation
// - Overrange flag twelve samples after input
// - Gain combinations only in modes 010..101
// - Coarse flag when fast level reaches or exceeds code
// - Coarse flag two samples after crossing
// - Coarse flag held at least two samples
// - Codes 000..111 map to rising trip levels
// - Fine high flag above 13-bit threshold
// - Fine low flag below 13-bit threshold
// - Lower gain uses coarse comparison
// - Raise gain after dwell below fine low
// - Dwell is 16 bits in sample clocks
// - 20-bit monitor result per channel, readable
// - Serial output sends each enabled result
// - Period is 24 bits, 128 up to 2^24
// - Peak mode by mode 1 or enable
// - Peak seeded then keeps larger magnitude
// - At count one store peak, reload, restart
// - Rms mode by mode 0 or enable
// - Square each sample, accumulate 24 bits
// - At count one store root, reload, restart
// - Pins delayed six samples in modes 1..3
// - Monitor runs only while enable bit set
`timescale 1ns/10ps
module level_monitor
    import level_monitor_pkg::*;
(
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    input  wire logic                        regWrite,
    input  wire logic                        regRead,
    input  wire logic [9:0]                  regAddr,
    input  wire logic [7:0]                  regWdata,
    output logic      [7:0]                  regRdata,
    input  wire logic [NCH-1:0]              overInput,
    input  wire logic [NCH-1:0][LVL_W-1:0]   fastLevel,
    input  wire logic [NCH-1:0][MAG_W-1:0]   magnitude,
    output logic      [NCH-1:0]              overrangeFlag,
    output logic      [NCH-1:0]              coarseHighTripFlag,
    output logic      [NCH-1:0]              fineHighTripFlag,
    output logic      [NCH-1:0]              fineLowTripFlag,
    output logic      [NCH-1:0]              raiseGainFlag,
    output logic      [NCH-1:0]              lowerGainFlag,
    output logic      [NCH-1:0][3:0]         fastDetectPins,
    output logic                             monSerialFrame,
    output logic                             monSerialData
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0]                     fdSel;    // Pin mode
        logic [2:0]                     coarse;   // Coarse code
        logic [15:0]                    fineHi;   // Fine high trip
        logic [15:0]                    fineLo;   // Fine low trip
        logic [DWELL_W-1:0]             dwell;    // Dwell time
        logic [7:0]                     serCtrl;  // Serial enables
        logic [7:0]                     monCtrl;  // Monitor control
        logic [PER_W-1:0]               period;   // Measure period
        logic [7:0]                     rdata;    // Read data
        logic                           monRun;   // Enable seen
        logic [NCH-1:0][OVR_LAT-1:0]    ovrPipe;  // Overrange delay
        logic [NCH-1:0][LVL_W-1:0]      lvl1;     // Fast level stage
        logic [NCH-1:0]                 cFlag;    // Coarse flag
        logic [NCH-1:0]                 cAged;    // Held two cycles
        logic [NCH-1:0]                 fHi;      // Fine high flag
        logic [NCH-1:0]                 fLo;      // Fine low flag
        logic [NCH-1:0][DWELL_W-1:0]    dwellCnt; // Low run length
        logic [NCH-1:0]                 raise;    // Raise gain
        logic [NCH-1:0][FD_SLOW-1:0][3:0] fdPipe; // Slow pin path
        logic [NCH-1:0][3:0]            fdOut;    // Pin outputs
        logic [NCH-1:0][PER_W-1:0]      perCnt;   // Period timer
        logic [NCH-1:0][MAG_W-1:0]      peak;     // Hidden peak
        logic [NCH-1:0][ACC_W-1:0]      acc;      // Power sum
        logic [NCH-1:0][RES_W-1:0]      xcnt;     // Crossing count
        logic [NCH-1:0][RES_W-1:0]      resRms;   // Held rms
        logic [NCH-1:0][RES_W-1:0]      resPeak;  // Held peak
        logic [NCH-1:0][RES_W-1:0]      resX;     // Held crossings
        logic [SER_W-1:0]               serShift; // Serial word
        logic [LEFT_W-1:0]              serLeft;  // Bits to send
        logic                           serFrame; // Frame pulse
        logic                           serData;  // Serial bit
    } state_t;

    state_t s;       // Registered state
    state_t next_s;  // Next state

    // ==========================================================
    // Helpers
    // Fast level clipped to three bits for the narrow pin modes
    function automatic logic [2:0] clip3(input logic [LVL_W-1:0] l);
        return l[LVL_W-1] ? 3'h7 : l[2:0];
    endfunction

    // Pin word for each mode; modes 6 and 7 carry nothing
    function automatic logic [3:0] fdWord(
        input logic [2:0] m, input logic [LVL_W-1:0] l,
        input logic ovr, input logic cu, input logic fu,
        input logic fl, input logic ig, input logic dg);
        logic [2:0] c;
        c = clip3(l);
        case (m)
            FD_MAG:       fdWord = l;
            FD_MAG_OVR:   fdWord = {c, ovr};
            FD_MAG_OVR_L: fdWord = {c[2:1], ovr, fl};
            FD_MAG_CU_L:  fdWord = {c[2:1], cu, fl};
            FD_TRIPS:     fdWord = {ovr, cu, fu, fl};
            FD_GAIN:      fdWord = {ovr, fu, ig, dg};
            default:      fdWord = 4'h0;
        endcase
    endfunction

    // Sample power; squaring exactly stands in for float squaring
    function automatic logic [PWR_W-1:0] power(
        input logic [MAG_W-1:0] m);
        logic [2*MAG_W-1:0] sq;
        sq = (2*MAG_W)'(m) * (2*MAG_W)'(m);
        return sq[2*MAG_W-1 -: PWR_W];
    endfunction

    // Saturating add keeps long periods from wrapping to small
    function automatic logic [ACC_W-1:0] accAdd(
        input logic [ACC_W-1:0] a, input logic [PWR_W-1:0] p);
        logic [ACC_W:0] sum;
        sum = {1'b0, a} + (ACC_W+1)'(p);
        return sum[ACC_W] ? '1 : sum[ACC_W-1:0];
    endfunction

    // Bitwise square root, one result bit per step
    function automatic logic [ROOT_W-1:0] isqrt(
        input logic [ACC_W-1:0] v);
        logic [ROOT_W-1:0] r;
        r = '0;
        for (int i = ROOT_W-1; i >= 0; i--) begin
            r[i] = 1'b1;
            if (ACC_W'(r) * ACC_W'(r) > v) begin
                r[i] = 1'b0;
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic run, start, doneNow, cmp, lo, hit;
        logic peakOn, rmsOn, xOn;
        logic [MAG_W-1:0] mag, peakNew;
        logic [ACC_W-1:0] accNew;
        logic [RES_W-1:0] xNew, word;
        logic [PWR_W-1:0] pwr;
        logic [7:0] rd;
        logic [9:0] idx;
        logic [1:0] nKind;
        logic [SER_W-1:0] pack;
        int pos;
        run = s.monCtrl[MON_EN_BIT];
        start = run & ~s.monRun;
        doneNow = 1'b0;
        cmp = 1'b0;
        lo = 1'b0;
        hit = 1'b0;
        peakOn = (s.monCtrl[MON_MODE_LSB+:2] == MON_PEAK)
                 | s.serCtrl[SER_PEAK_BIT];
        rmsOn = (s.monCtrl[MON_MODE_LSB+:2] == MON_RMS)
                | s.serCtrl[SER_RMS_BIT];
        xOn = s.monCtrl[MON_MODE_LSB+1] | s.serCtrl[SER_XING_BIT];
        mag = '0;
        peakNew = '0;
        accNew = '0;
        xNew = '0;
        word = '0;
        pwr = '0;
        rd = BYTE_RST;
        idx = '0;
        nKind = '0;
        pack = '0;
        pos = 0;
        next_s = s;
        next_s.monRun = run;
        next_s.serFrame = 1'b0;

        // Register writes, byte-wide at their own offsets
        if (regWrite) begin
            case (regAddr)
                ADR_FD_SEL: next_s.fdSel = regWdata[FD_SEL_LSB+:3];
                ADR_COARSE: next_s.coarse = regWdata[2:0];
                ADR_FHI_L:  next_s.fineHi[7:0] = regWdata;
                ADR_FHI_H:  next_s.fineHi[15:8] = regWdata;
                ADR_FLO_L:  next_s.fineLo[7:0] = regWdata;
                ADR_FLO_H:  next_s.fineLo[15:8] = regWdata;
                ADR_DWL_L:  next_s.dwell[7:0] = regWdata;
                ADR_DWL_H:  next_s.dwell[15:8] = regWdata;
                ADR_SER:    next_s.serCtrl = regWdata;
                ADR_MON:    next_s.monCtrl = regWdata;
                ADR_PER0:   next_s.period[7:0] = regWdata;
                ADR_PER1:   next_s.period[15:8] = regWdata;
                ADR_PER2:   next_s.period[23:16] = regWdata;
                default:    ;                   // Unmapped: ignored
            endcase
        end

        // Channels run side by side with no shared state
        for (int c = 0; c < NCH; c++) begin
            mag = magnitude[c];
            next_s.ovrPipe[c] = {s.ovrPipe[c][OVR_LAT-2:0],
                                 overInput[c]};
            next_s.lvl1[c] = fastLevel[c];
            // Level code n already means above the n-th trip level
            cmp = s.lvl1[c] >= {1'b0, s.coarse};
            // Age bit stops a one-sample blip from releasing early
            next_s.cFlag[c] = cmp | (s.cFlag[c] & ~s.cAged[c]);
            next_s.cAged[c] = s.cFlag[c] & next_s.cFlag[c];
            next_s.fHi[c] = mag > s.fineHi[MAG_W-1:0];
            lo = mag < s.fineLo[MAG_W-1:0];
            next_s.fLo[c] = lo;
            // Run length of low samples, saturating at full count
            if (!lo) begin
                next_s.dwellCnt[c] = '0;
            end else if (s.dwellCnt[c] != '1) begin
                next_s.dwellCnt[c] = s.dwellCnt[c] + 1'b1;
            end
            next_s.raise[c] = lo
                && (next_s.dwellCnt[c] >= s.dwell);

            // Fast detect pins; slow modes take the longer path
            next_s.fdPipe[c][0] = fdWord(s.fdSel, s.lvl1[c],
                s.ovrPipe[c][OVR_LAT-1], s.cFlag[c], s.fHi[c],
                s.fLo[c], s.raise[c], s.cFlag[c]);
            for (int k = 1; k < FD_SLOW; k++) begin
                next_s.fdPipe[c][k] = s.fdPipe[c][k-1];
            end
            if (s.fdSel >= FD_MAG_OVR && s.fdSel <= FD_MAG_CU_L) begin
                next_s.fdOut[c] = s.fdPipe[c][FD_SLOW-1];
            end else begin
                next_s.fdOut[c] = next_s.fdPipe[c][0];
            end

            // Monitor: all three measures share one period timer
            pwr = power(mag);
            hit = mag > s.fineHi[MAG_W-1:0];
            peakNew = (mag > s.peak[c]) ? mag : s.peak[c];
            accNew = accAdd(s.acc[c], pwr);
            xNew = s.xcnt[c] + RES_W'(hit);    // Wraps, period permitting
            if (!run) begin
                next_s.perCnt[c] = '0;
            end else if (start) begin
                // Start sample counts, so load one short of the period
                next_s.perCnt[c] = s.period - 1'b1;
                next_s.peak[c] = mag;
                next_s.acc[c] = ACC_W'(pwr);
                next_s.xcnt[c] = RES_W'(hit);
            end else if (s.perCnt[c] == PER_W'(1)) begin
                if (peakOn) begin
                    next_s.resPeak[c] = RES_W'(peakNew);
                end
                if (rmsOn) begin
                    next_s.resRms[c] =
                        RES_W'(isqrt(accNew)) << RES_SHIFT;
                end
                if (xOn) begin
                    next_s.resX[c] = xNew;
                end
                next_s.perCnt[c] = s.period;
                next_s.peak[c] = '0;       // Next sample seeds the peak
                next_s.acc[c] = '0;
                next_s.xcnt[c] = '0;
                doneNow = 1'b1;
            end else begin
                next_s.perCnt[c] = s.perCnt[c] - 1'b1;
                next_s.peak[c] = peakNew;
                next_s.acc[c] = accNew;
                next_s.xcnt[c] = xNew;
            end
        end

        // Serial output: channel A then B, rms, peak, crossings
        nKind = 2'(s.serCtrl[SER_RMS_BIT]) + 2'(s.serCtrl[SER_PEAK_BIT])
              + 2'(s.serCtrl[SER_XING_BIT]);
        if (doneNow && nKind != 2'h0) begin
            for (int c = 0; c < NCH; c++) begin
                for (int k = 0; k < NKIND; k++) begin
                    word = (k == 0) ? next_s.resRms[c]
                         : (k == 1) ? next_s.resPeak[c]
                         : next_s.resX[c];
                    if (s.serCtrl[k]) begin
                        pack[SER_W-1-pos -: RES_W] = word;
                        pos = pos + RES_W;
                    end
                end
            end
            next_s.serShift = pack;
            next_s.serLeft = LEFT_W'(NCH * RES_W * int'(nKind));
            next_s.serFrame = 1'b1;
            next_s.serData = 1'b0;
        end else if (s.serLeft != '0) begin
            next_s.serData = s.serShift[SER_W-1];
            next_s.serShift = {s.serShift[SER_W-2:0], 1'b0};
            next_s.serLeft = s.serLeft - 1'b1;
        end else begin
            next_s.serData = 1'b0;
        end

        // Register reads answer on the next edge
        if (regAddr >= ADR_RES && regAddr <= ADR_RES_END) begin
            idx = regAddr - ADR_RES;
            word = (s.monCtrl[MON_MODE_LSB+1]) ? s.resX[idx / 3]
                 : (s.monCtrl[MON_MODE_LSB+:2] == MON_PEAK)
                   ? s.resPeak[idx / 3] : s.resRms[idx / 3];
            rd = 8'(word >> (8 * (idx % 3)));
        end else begin
            case (regAddr)
                ADR_FD_SEL: rd = {4'h0, s.fdSel, 1'b0};
                ADR_COARSE: rd = {5'h00, s.coarse};
                ADR_FHI_L:  rd = s.fineHi[7:0];
                ADR_FHI_H:  rd = s.fineHi[15:8];
                ADR_FLO_L:  rd = s.fineLo[7:0];
                ADR_FLO_H:  rd = s.fineLo[15:8];
                ADR_DWL_L:  rd = s.dwell[7:0];
                ADR_DWL_H:  rd = s.dwell[15:8];
                ADR_SER:    rd = s.serCtrl;
                ADR_MON:    rd = s.monCtrl;
                ADR_PER0:   rd = s.period[7:0];
                ADR_PER1:   rd = s.period[15:8];
                ADR_PER2:   rd = s.period[23:16];
                default:    rd = BYTE_RST;
            endcase
        end
        if (regRead) begin
            next_s.rdata = rd;
        end
    end

    // ==========================================================
    // State register, synchronous reset clears everything
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs, all straight from flip-flops
    always_comb begin
        regRdata = s.rdata;
        monSerialFrame = s.serFrame;
        monSerialData = s.serData;
        fastDetectPins = s.fdOut;
        coarseHighTripFlag = s.cFlag;
        lowerGainFlag = s.cFlag;
        fineHighTripFlag = s.fHi;
        fineLowTripFlag = s.fLo;
        raiseGainFlag = s.raise;
        for (int c = 0; c < NCH; c++) begin
            overrangeFlag[c] = s.ovrPipe[c][OVR_LAT-1];
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence coarseCross;
        fastLevel[0] >= {1'b0, s.coarse} ##1 $stable(s.coarse);
    endsequence
    sequence slowModeZero;
        (s.fdSel == FD_MAG_OVR && fastLevel[0] == 4'h0)
        ##1 (s.fdSel == FD_MAG_OVR) [*6];
    endsequence

    chk_ovr_delay: assert property (
        overInput[0] |-> ##12 overrangeFlag[0])
        else $error("overrange flag not twelve cycles later");
    chk_coarse_rise: assert property (
        coarseCross |-> ##1 coarseHighTripFlag[0])
        else $error("coarse flag missing two cycles after cross");
    chk_coarse_hold: assert property (
        $rose(coarseHighTripFlag[0]) |=> coarseHighTripFlag[0])
        else $error("coarse flag released after one cycle");
    chk_gain_modes: assert property (
        s.fdSel == 3'h6 ##1 s.fdSel == 3'h6 |-> fastDetectPins[0] == 4'h0)
        else $error("pins active in mode without gain combos");
    chk_lower_gain: assert property (
        $rose(lowerGainFlag[0]) |-> $past(s.lvl1[0]) >= $past(s.coarse))
        else $error("lower gain rose without coarse crossing");
    chk_fine_high: assert property (
        magnitude[0] > s.fineHi[MAG_W-1:0] |=> fineHighTripFlag[0])
        else $error("fine high flag missing");
    chk_fine_low: assert property (
        magnitude[1] < s.fineLo[MAG_W-1:0] |=> fineLowTripFlag[1])
        else $error("fine low flag missing");
    chk_raise_dwell: assert property (
        raiseGainFlag[0] |-> fineLowTripFlag[0]
            && s.dwellCnt[0] >= s.dwell)
        else $error("raise gain before dwell elapsed");
    chk_slow_pins: assert property (
        slowModeZero |-> fastDetectPins[0][3:1] == 3'h0)
        else $error("slow pin mode latency not six");
    chk_peak_store: assert property (
        s.monRun && s.monCtrl[MON_EN_BIT] && s.perCnt[0] == 24'h000001
        && s.monCtrl[2:1] == MON_PEAK
        |=> s.resPeak[0] >= RES_W'($past(magnitude[0])) && s.peak[0] == '0)
        else $error("peak not stored at end of period");
    chk_monitor_off: assert property (
        !s.monCtrl[MON_EN_BIT] |=> s.perCnt[1] == '0)
        else $error("monitor timer runs while disabled");

endmodule // level_monitor

/* tb/gain_ctrl_model.sv */
// Behavioural external gain stepper fed by the gain flags
`timescale 1ns/10ps
module gain_ctrl_model (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       raise,
    input  wire logic       lower,
    output logic      [3:0] gainStep
);
    // ==========================================================
    // Lowering wins except at step 0, where a raise still steps the gain up
    always_ff @(posedge mclk) begin
        if (!rst_n) gainStep <= 4'h0;
        else if (lower && gainStep != 4'h0) gainStep <= gainStep - 4'h1;
        else if (raise && gainStep != 4'hF) gainStep <= gainStep + 4'h1;
    end
endmodule // gain_ctrl_model

/* tb/tb.sv */
// Self-checking bench for the level monitor block
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module tb;
    import level_monitor_pkg::*;
    // ==========================================================
    // Stimulus, observed outputs and table rows
    typedef struct {logic [12:0] mag; logic hi; logic lo;} row_t;
    logic mclk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [9:0] regAddr; logic [7:0] regWdata, regRdata, rv;
    logic [1:0] overInput, overrangeFlag, coarseHighTripFlag;
    logic [1:0] fineHighTripFlag, fineLowTripFlag, raiseGainFlag;
    logic [1:0] lowerGainFlag;
    logic monSerialFrame, monSerialData;
    logic [39:0] sbits;  // Serial bits gathered after a frame pulse
    logic [1:0][3:0] fastLevel, fastDetectPins;
    logic [1:0][12:0] magnitude;
    int miscompares = 0, checks = 0, cycles = 0;
    // Last row stays high so the dwell test starts from a clean count
    row_t rows [4] = '{'{13'h1001, 1'b1, 1'b0}, '{13'h1000, 1'b0, 1'b0},
                       '{13'h00FF, 1'b0, 1'b1}, '{13'h1001, 1'b1, 1'b0}};
    level_monitor uut (.mclk(mclk), .rst_n(rst_n), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .overInput(overInput), .fastLevel(fastLevel),
        .magnitude(magnitude), .overrangeFlag(overrangeFlag),
        .coarseHighTripFlag(coarseHighTripFlag),
        .fineHighTripFlag(fineHighTripFlag), .fineLowTripFlag(fineLowTripFlag),
        .raiseGainFlag(raiseGainFlag), .lowerGainFlag(lowerGainFlag),
        .fastDetectPins(fastDetectPins), .monSerialFrame(monSerialFrame),
        .monSerialData(monSerialData));
    gain_ctrl_model ctrl (.mclk(mclk), .rst_n(rst_n), .raise(raiseGainFlag[0]),
        .lower(lowerGainFlag[0]), .gainStep());
    // ==========================================================
    // Clock, hang guard and bus tasks
    initial forever #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            summarize();
        end
    end
    task summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Settle past the edge so registered outputs have landed
    task step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWrite <= 1'b1; regAddr <= a; regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    task rd(input logic [9:0] a);
        @(posedge mclk);
        regRead <= 1'b1; regAddr <= a;
        step(1);
        rv = regRdata;
        regRead <= 1'b0;
    endtask
    // ==========================================================
    // Main sequence: reset, table rows, then hand-written cases
    initial begin
        overInput = '0; fastLevel = '0; magnitude = '0;
        regAddr = '0; regWdata = '0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        step(1);
        `CHK(overrangeFlag, 2'h0)
        rd(ADR_RES); `CHK(rv, 8'h00)
        rd(10'h1FF); `CHK(rv, 8'h00)
        wr(ADR_COARSE, 8'h07); wr(ADR_FHI_H, 8'h10); wr(ADR_FLO_H, 8'h01);
        wr(ADR_FD_SEL, 8'h08); wr(ADR_DWL_L, 8'h04); wr(ADR_DWL_H, 8'h00);
        rd(ADR_FLO_H); `CHK(rv, 8'h01)
        foreach (rows[i]) begin
            @(posedge mclk); magnitude[0] <= rows[i].mag;
            step(5);
            `CHK(fineHighTripFlag[0], rows[i].hi)
            `CHK(fineLowTripFlag[0], rows[i].lo)
            rv = {6'h00, rows[i].hi, rows[i].lo};
            `CHK(fastDetectPins[0], rv[3:0])
        end
        // Dwell of four low samples before the gain-up flag
        @(posedge mclk); magnitude[0] <= 13'h0000;
        step(3); `CHK(raiseGainFlag[0], 1'b0)
        step(1); `CHK(raiseGainFlag[0], 1'b1)
        for (int k = 1; k < 8; k++) begin
            wr(ADR_COARSE, 8'(k));
            @(posedge mclk); fastLevel[0] <= 4'(k - 1);
            step(4); `CHK(coarseHighTripFlag[0], 1'b0)
            @(posedge mclk); fastLevel[0] <= 4'(k);
            step(4); `CHK(coarseHighTripFlag[0], 1'b1)
        end
        @(posedge mclk); fastLevel[0] <= 4'h0;
        step(4);
        // One-sample spike must still give a two-cycle flag
        @(posedge mclk); fastLevel[0] <= 4'h8;
        @(posedge mclk); fastLevel[0] <= 4'h0;
        #1 `CHK(coarseHighTripFlag[0], 1'b0)
        step(1); `CHK(coarseHighTripFlag[0], 1'b1)
        `CHK(lowerGainFlag[0], 1'b1)
        step(1); `CHK(coarseHighTripFlag[0], 1'b1)
        step(1); `CHK(coarseHighTripFlag[0], 1'b0)
        // Gain mode shows the raise flag; mode 6 keeps the pins dark
        wr(ADR_FD_SEL, 8'h0A);
        step(2); `CHK(fastDetectPins[0], 4'h2)
        wr(ADR_FD_SEL, 8'h0C);
        step(3); `CHK(fastDetectPins[0], 4'h0)
        // Narrow magnitude mode takes the six-cycle path
        wr(ADR_FD_SEL, 8'h02); step(8);
        @(posedge mclk); fastLevel[0] <= 4'h3;
        step(5); `CHK(fastDetectPins[0], 4'h0)
        step(1); `CHK(fastDetectPins[0], 4'h6)
        @(posedge mclk); overInput <= 2'h1;
        step(11); `CHK(overrangeFlag, 2'h0)
        step(1); `CHK(overrangeFlag, 2'h1)
        @(posedge mclk); magnitude <= {13'h0123, 13'h0ABC};
        wr(ADR_PER0, 8'h80); wr(ADR_PER1, 8'h00);
        wr(ADR_PER2, 8'h00); wr(ADR_SER, 8'h02);
        wr(ADR_MON, 8'h03);
        // Peak words of both channels leave MSB first after the frame
        @(posedge monSerialFrame);
        repeat (40) begin
            step(1);
            sbits = {sbits[38:0], monSerialData};
        end
        `CHK(sbits, 40'h00ABC00123)
        `CHK(monSerialFrame, 1'b0)
        rd(ADR_RES); `CHK(rv, 8'hBC)
        rd(10'h117); `CHK(rv, 8'h0A)
        rd(10'h119); `CHK(rv, 8'h23)
        // Mode 0 turns readback to the root of the summed power
        wr(ADR_MON, 8'h01);
        step(128);
        rd(10'h117); `CHK(rv, 8'hAB)
        summarize();
    end
endmodule // tb
